// ---- hdl/tec_timer.sv ----
// Function
// - 32-bit up counter behind an 8-bit prescaler, readable at any time.
// - Counting clock from bus clock, low-speed clock or pin clock input.
// - Compare flag sets on every count and compare match.
// - Compare interrupt flag sets on match only when enabled; drives timer interrupt.
// - Capture flag sets on every selected capture pin edge in free capture, and only on the second edge in trigger mode.
// - Capture interrupt flag sets only when enabled; drives capture interrupt.
// - Mode field: 00 one-shot, 01 periodic, 10 toggle, 11 continuous.
// - One-shot match sets flag, clears count and count enable, stops.
// - Periodic match sets flag, clears count, keeps counting.
// - Periodic cycle repeats until software clears count enable.
// - Toggle mode counts periodically and inverts idle-high output on interrupt flag.
// - Continuous match keeps counting, wraps after all ones to zero.
// - Continuous mode accepts new compare values without stopping.
// - Continuous mode compares three slots; other modes only the first.
// - Event counting increments count on each detected pin event.
// - Event input has optional debounce and selectable counted edge.
// - Event counting works with one-shot, periodic and continuous compare.
// - Free capture copies count on selected edge: 00 fall, 01 rise, 10 both.
// - Captured value holds while capture interrupt flag stays set.
// - External reset select makes capture edge clear the count in free capture only.
// - Trigger mode: first edge clears and starts, second edge captures and flags.
// - Trigger mode when style 1, capture enabled and reset select 0.
// - Capture interrupt flag clears only on a written one.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module tec_timer (
    input  wire logic             mclk,
    input  wire logic             rstn,
    input  wire tec_pkg::tec_bus_s bus,
    output logic [31:0]           rdata,
    input  wire logic             clk_lo_in,
    input  wire logic             pin_clock_input,
    input  wire logic             event_pin,
    input  wire logic             capture_pin,
    output logic                  toggle_out_pin,
    output logic                  timer_irq,
    output logic                  capture_irq
);
    import tec_pkg::*;

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Debounce: with filter on, level changes only after three equal samples
    function automatic logic filt(input logic [2:0] hist, input logic db, input logic keep);
        logic res;
        res = hist[0];
        if (db) begin
            res = (&hist) ? 1'b1 : ((|hist) ? keep : 1'b0);
        end
        return res;
    endfunction : filt

    // Edge match against an edge selection
    function automatic logic edge_hit(input logic prv, input logic cur, input logic [1:0] sel);
        logic res;
        res = 1'b0;
        if (sel == EDGE_FALL) begin
            res = prv & ~cur;
        end else if (sel == EDGE_RISE) begin
            res = ~prv & cur;
        end else if (sel == EDGE_BOTH) begin
            res = prv ^ cur;
        end
        return res;
    endfunction : edge_hit

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic rst_meta_q;
    logic rst_n_q;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ****************************************************************
    // State
    // ****************************************************************
    tec_ctl_s    ctl_q,  ctl_d;
    tec_ext_s    ext_q;
    logic [31:0] cmp_q [0:2];
    logic [31:0] cnt_q,  cnt_d;
    logic [7:0]  psc_q,  psc_d;
    logic [31:0] cap_q;
    logic        kflag_q, kirq_q;
    logic        cflag_q, cirq_q;
    logic        tog_q;
    tec_trig_e   trig_q, trig_d;
    logic        lo_prev_q, pin_prev_q;
    logic [2:0]  evt_hist_q, cap_hist_q;
    logic        evt_lvl_q, evt_prev_q;
    logic        cap_lvl_q, cap_prev_q;
    logic [31:0] rdata_q;

    // ****************************************************************
    // Register decode
    // ****************************************************************
    wire wr_ctl  = bus.wr && (bus.addr == OFS_CTRL);
    wire wr_ext  = bus.wr && (bus.addr == OFS_EXT_CTRL);
    wire wr_ksts = bus.wr && (bus.addr == OFS_CMP_STS);
    wire wr_csts = bus.wr && (bus.addr == OFS_CAP_STS);
    wire wr_cmp0 = bus.wr && (bus.addr == OFS_CMP0);
    wire wr_cmp1 = bus.wr && (bus.addr == OFS_CMP1);
    wire wr_cmp2 = bus.wr && (bus.addr == OFS_CMP2);
    wire clr_cnt = wr_ctl && bus.wdata[CTL_RST_BIT];
    wire clr_kirq  = wr_ksts && bus.wdata[STS_IRQ_BIT];
    wire clr_kflag = wr_ksts && bus.wdata[STS_FLAG_BIT];
    wire clr_cirq  = wr_csts && bus.wdata[STS_IRQ_BIT];
    wire clr_cflag = wr_csts && bus.wdata[STS_FLAG_BIT];

    // ****************************************************************
    // Clock source and prescaler
    // ****************************************************************
    wire lo_rise  = clk_lo_in & ~lo_prev_q;
    wire pin_rise = pin_clock_input & ~pin_prev_q;
    wire src_tick = (ctl_q.src == SRC_BUS) ? 1'b1 :
                    (ctl_q.src == SRC_LO)  ? lo_rise :
                    (ctl_q.src == SRC_PIN) ? pin_rise : 1'b0;
    wire psc_wrap = src_tick && (psc_q == ctl_q.psc);

    // ****************************************************************
    // Input filters and edge detection
    // ****************************************************************
    wire evt_lvl_d = filt(evt_hist_q, ext_q.evdb, evt_lvl_q);
    wire cap_lvl_d = filt(cap_hist_q, ext_q.capdb, cap_lvl_q);
    wire evt_edge  = edge_hit(evt_prev_q, evt_lvl_q,
                              ext_q.phase ? EDGE_RISE : EDGE_FALL);
    wire cap_evt   = ext_q.cen && edge_hit(cap_prev_q, cap_lvl_q, ext_q.edge_sel);

    // ****************************************************************
    // Capture mode decode
    // ****************************************************************
    wire free_mode  = ~ext_q.style;
    wire trig_mode  = ext_q.style && ext_q.cen && !ext_q.crst;
    wire ext_reset  = cap_evt && free_mode && ext_q.crst;
    wire trig_start = cap_evt && trig_mode && (trig_q == trig_idle);
    wire trig_stop  = cap_evt && trig_mode && (trig_q == trig_run);
    wire cap_set    = cap_evt && (free_mode || trig_stop);
    wire cnt_force  = clr_cnt || trig_start || ext_reset;

    // ****************************************************************
    // Counting and compare
    // ****************************************************************
    wire run   = ctl_q.en && (!trig_mode || (trig_q == trig_run));
    wire step  = run && (ctl_q.evt ? evt_edge : psc_wrap);
    wire hit0  = (cnt_q == cmp_q[0]);
    wire hit12 = (cnt_q == cmp_q[1]) || (cnt_q == cmp_q[2]);
    wire cont  = (ctl_q.mode == MODE_CONT);
    wire match = step && (hit0 || (cont && hit12));
    wire restart = match && !cont;
    wire oneshot_stop = match && (ctl_q.mode == MODE_ONESHOT);
    wire kirq_set = match && ctl_q.ien;

    // Counter next value: forced clears win, then restart, then step
    always_comb begin
        cnt_d = cnt_q;
        if (cnt_force || restart) begin
            cnt_d = 32'h0000_0000;
        end else if (step) begin
            cnt_d = cnt_q + 32'h0000_0001;
        end
    end

    // Prescaler next value
    always_comb begin
        psc_d = psc_q;
        if (clr_cnt || trig_start) begin
            psc_d = 8'h00;
        end else if (run && src_tick) begin
            psc_d = psc_wrap ? 8'h00 : psc_q + 8'h01;
        end
    end

    // Control next value; hardware stop and counter reset win over the write
    always_comb begin
        ctl_d = ctl_q;
        if (wr_ctl) begin
            ctl_d.en   = bus.wdata[CTL_EN_BIT];
            ctl_d.ien  = bus.wdata[CTL_IEN_BIT];
            ctl_d.mode = bus.wdata[CTL_MODE_LSB +: 2];
            ctl_d.evt  = bus.wdata[CTL_EVT_BIT];
            ctl_d.src  = bus.wdata[CTL_SRC_LSB +: 2];
            ctl_d.psc  = bus.wdata[CTL_PSC_LSB +: 8];
        end
        if (oneshot_stop || clr_cnt) begin
            ctl_d.en = 1'b0;
        end
    end

    // Trigger-counting state
    always_comb begin
        trig_d = trig_q;
        unique case (trig_q)
            trig_idle: if (trig_start) trig_d = trig_run;
            trig_run:  if (trig_stop || !trig_mode) trig_d = trig_idle;
        endcase
    end

    // ****************************************************************
    // Read mux
    // ****************************************************************
    wire [31:0] ctl_rd = {1'b0, ctl_q.en, ctl_q.ien, ctl_q.mode, 2'h0, ctl_q.evt,
                          14'h0000, ctl_q.src, ctl_q.psc};
    wire [31:0] rd_mux =
        (bus.addr == OFS_CTRL)     ? ctl_rd :
        (bus.addr == OFS_CMP0)     ? cmp_q[0] :
        (bus.addr == OFS_CMP_STS)  ? {30'h0000_0000, kflag_q, kirq_q} :
        (bus.addr == OFS_COUNT)    ? cnt_q :
        (bus.addr == OFS_CAPTURE)  ? cap_q :
        (bus.addr == OFS_EXT_CTRL) ? {23'h00_0000, ext_q} :
        (bus.addr == OFS_CAP_STS)  ? {30'h0000_0000, cflag_q, cirq_q} :
        (bus.addr == OFS_CMP1)     ? cmp_q[1] :
        (bus.addr == OFS_CMP2)     ? cmp_q[2] : 32'h0000_0000;

    // ****************************************************************
    // Registers
    // ****************************************************************

    // Software-visible configuration
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctl_q    <= tec_ctl_s'({CTL_RESET[30:27], CTL_RESET[24], CTL_RESET[9:0]});
            ext_q    <= '0;
            cmp_q[0] <= 32'h0000_0000;
            cmp_q[1] <= 32'h0000_0000;
            cmp_q[2] <= 32'h0000_0000;
        end else begin
            ctl_q <= ctl_d;
            if (wr_ext) ext_q <= tec_ext_s'(bus.wdata[8:0]);
            if (wr_cmp0) cmp_q[0] <= bus.wdata;
            if (wr_cmp1) cmp_q[1] <= bus.wdata;
            if (wr_cmp2) cmp_q[2] <= bus.wdata;
        end
    end

    // Counter, prescaler and trigger state
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cnt_q  <= 32'h0000_0000;
            psc_q  <= 8'h00;
            trig_q <= trig_idle;
        end else begin
            cnt_q  <= cnt_d;
            psc_q  <= psc_d;
            trig_q <= trig_d;
        end
    end

    // Compare flags and toggle output; set wins over clear
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            kflag_q <= 1'b0;
            kirq_q  <= 1'b0;
            tog_q   <= 1'b1;
        end else begin
            kflag_q <= match | (kflag_q & ~clr_kflag);
            kirq_q  <= kirq_set | (kirq_q & ~clr_kirq);
            if (kirq_set && ctl_q.mode == MODE_TOGGLE) tog_q <= ~tog_q;
        end
    end

    // Capture flags and captured value
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cflag_q <= 1'b0;
            cirq_q  <= 1'b0;
            cap_q   <= 32'h0000_0000;
        end else begin
            cflag_q <= cap_set | (cflag_q & ~clr_cflag);
            cirq_q  <= (cap_set & ext_q.cien) | (cirq_q & ~clr_cirq);
            if (cap_set && !cirq_q) cap_q <= cnt_q;
        end
    end

    // Input sampling and filtering
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            lo_prev_q  <= 1'b0;
            pin_prev_q <= 1'b0;
            evt_hist_q <= 3'h0;
            cap_hist_q <= 3'h0;
            evt_lvl_q  <= 1'b0;
            evt_prev_q <= 1'b0;
            cap_lvl_q  <= 1'b0;
            cap_prev_q <= 1'b0;
        end else begin
            lo_prev_q  <= clk_lo_in;
            pin_prev_q <= pin_clock_input;
            evt_hist_q <= {evt_hist_q[1:0], event_pin};
            cap_hist_q <= {cap_hist_q[1:0], capture_pin};
            evt_lvl_q  <= evt_lvl_d;
            evt_prev_q <= evt_lvl_q;
            cap_lvl_q  <= cap_lvl_d;
            cap_prev_q <= cap_lvl_q;
        end
    end

    // Read data stands only in the cycle after the read strobe
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= bus.rd ? rd_mux : 32'h0000_0000;
        end
    end

    // Outputs
    assign rdata          = rdata_q;
    assign toggle_out_pin = tog_q;
    assign timer_irq      = kirq_q;
    assign capture_irq    = cirq_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_count_read: assert property (@(posedge mclk) disable iff (!rst_n_q)
        bus.rd && bus.addr == OFS_COUNT |=> rdata == $past(cnt_q))
        else $error("count read returned wrong value");

    chk_flag_on_match: assert property (@(posedge mclk) disable iff (!rst_n_q)
        match |=> kflag_q)
        else $error("compare flag missed a match");

    chk_irq_gated: assert property (@(posedge mclk) disable iff (!rst_n_q)
        !kirq_q && !(match && ctl_q.ien) |=> !kirq_q && !timer_irq)
        else $error("compare interrupt set without enable");

    chk_oneshot_stop: assert property (@(posedge mclk) disable iff (!rst_n_q)
        oneshot_stop && !wr_ctl |=> cnt_q == 32'h0000_0000 && !ctl_q.en ##1 !ctl_q.en)
        else $error("one-shot did not stop");

    chk_periodic_go: assert property (@(posedge mclk) disable iff (!rst_n_q)
        match && ctl_q.mode == MODE_PERIODIC && !wr_ctl |=> cnt_q == 32'h0000_0000 && ctl_q.en)
        else $error("periodic restart wrong");

    chk_toggle_flip: assert property (@(posedge mclk) disable iff (!rst_n_q)
        kirq_set && ctl_q.mode == MODE_TOGGLE |=> toggle_out_pin != $past(toggle_out_pin))
        else $error("toggle output did not invert");

    chk_cont_keeps: assert property (@(posedge mclk) disable iff (!rst_n_q)
        match && cont && !cnt_force |=> cnt_q == $past(cnt_q) + 32'h0000_0001)
        else $error("continuous match disturbed count");

    chk_cap_flag: assert property (@(posedge mclk) disable iff (!rst_n_q)
        cap_set |=> cflag_q)
        else $error("capture flag missed");

    chk_cap_hold: assert property (@(posedge mclk) disable iff (!rst_n_q)
        cirq_q |=> $stable(cap_q))
        else $error("captured value changed while flag set");

    chk_ext_clear: assert property (@(posedge mclk) disable iff (!rst_n_q)
        ext_reset |=> cnt_q == 32'h0000_0000)
        else $error("external reset did not clear count");

    chk_cirq_sticky: assert property (@(posedge mclk) disable iff (!rst_n_q)
        cirq_q && !clr_cirq |=> cirq_q)
        else $error("capture interrupt flag lost");

endmodule : tec_timer

`default_nettype wire

// ---- hdl/tec_pkg.sv ----
// ****************************************************************
// Timer with event capture: shared constants and types
// ****************************************************************
package tec_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_CMP0     = 8'h04;
    localparam logic [7:0] OFS_CMP_STS  = 8'h08;
    localparam logic [7:0] OFS_COUNT    = 8'h0C;
    localparam logic [7:0] OFS_CAPTURE  = 8'h10;
    localparam logic [7:0] OFS_EXT_CTRL = 8'h14;
    localparam logic [7:0] OFS_CAP_STS  = 8'h18;
    localparam logic [7:0] OFS_CMP1     = 8'h1C;
    localparam logic [7:0] OFS_CMP2     = 8'h20;

    // Control register field positions and reset value
    localparam int unsigned CTL_EN_BIT   = 30;
    localparam int unsigned CTL_IEN_BIT  = 29;
    localparam int unsigned CTL_MODE_LSB = 27;
    localparam int unsigned CTL_RST_BIT  = 26;
    localparam int unsigned CTL_EVT_BIT  = 24;
    localparam int unsigned CTL_SRC_LSB  = 8;
    localparam int unsigned CTL_PSC_LSB  = 0;
    localparam logic [31:0] CTL_RESET    = 32'h0000_0005;

    // Status register bit positions (both status registers)
    localparam int unsigned STS_IRQ_BIT  = 0;
    localparam int unsigned STS_FLAG_BIT = 1;

    // Counting modes
    localparam logic [1:0] MODE_ONESHOT  = 2'h0;
    localparam logic [1:0] MODE_PERIODIC = 2'h1;
    localparam logic [1:0] MODE_TOGGLE   = 2'h2;
    localparam logic [1:0] MODE_CONT     = 2'h3;

    // Edge selections
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;

    // Counting clock sources
    localparam logic [1:0] SRC_BUS = 2'h0;
    localparam logic [1:0] SRC_LO  = 2'h1;
    localparam logic [1:0] SRC_PIN = 2'h2;

    // Trigger-counting capture state
    typedef enum logic {trig_idle, trig_run} tec_trig_e;

    // Register bus request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } tec_bus_s;

    // Control register contents
    typedef struct packed {
        logic       en;
        logic       ien;
        logic [1:0] mode;
        logic       evt;
        logic [1:0] src;
        logic [7:0] psc;
    } tec_ctl_s;

    // External control register contents, in bit order 8 down to 0
    typedef struct packed {
        logic       style;
        logic       evdb;
        logic       capdb;
        logic       cien;
        logic       crst;
        logic       cen;
        logic [1:0] edge_sel;
        logic       phase;
    } tec_ext_s;

endpackage : tec_pkg

// ---- bench/tec_pins.sv ----
`timescale 1ns/10ps
`default_nettype none
// ********
// Pin side: event and capture inputs, slow and pin clocks
// ********
module tec_pins (
    input  wire logic mclk,
    input  wire logic evt_req,
    input  wire logic cap_req,
    output var logic  event_pin,
    output var logic  capture_pin,
    output var logic  clk_lo_in,
    output var logic  pin_clock_input
);
    int ev_gap;
    int cap_gap;
    int tick;

    // Pins start low
    initial begin
        ev_gap = 0;
        cap_gap = 0;
        tick = 0;
        event_pin = 1'b0;
        capture_pin = 1'b0;
        clk_lo_in = 1'b0;
        pin_clock_input = 1'b0;
    end

    // Pins follow requests, edges at least 8 bus cycles apart
    always @(posedge mclk) begin
        tick <= tick + 1;
        ev_gap <= ev_gap + 1;
        cap_gap <= cap_gap + 1;
        if (event_pin != evt_req && ev_gap >= 8) begin
            event_pin <= evt_req;
            ev_gap <= 0;
        end
        if (capture_pin != cap_req && cap_gap >= 8) begin
            capture_pin <= cap_req;
            cap_gap <= 0;
        end
        clk_lo_in <= (tick % 20) < 10;      // Slow clock, 20 bus cycles
        pin_clock_input <= (tick % 10) < 5; // Pin clock, 10 bus cycles
    end
endmodule : tec_pins
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
// ********
// Timer bench
// ********
module testbench;
    import tec_pkg::*;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    tec_bus_s    bus = '0;
    logic [31:0] rdata, v, w;
    logic        lo_clk, pin_clk, ev_pin, cap_pin, tog, t_irq, c_irq;
    logic        ev_req = 1'b0;
    logic        cap_req = 1'b0;
    int          fails = 0;
    int          cmp_count = 0;

    // Bus clock, 40 ns
    always #20 mclk = ~mclk;

    tec_timer dut (.mclk(mclk), .rstn(rstn), .bus(bus), .rdata(rdata), .clk_lo_in(lo_clk),
        .pin_clock_input(pin_clk), .event_pin(ev_pin), .capture_pin(cap_pin),
        .toggle_out_pin(tog), .timer_irq(t_irq), .capture_irq(c_irq));
    tec_pins pins (.mclk(mclk), .evt_req(ev_req), .cap_req(cap_req), .event_pin(ev_pin),
        .capture_pin(cap_pin), .clk_lo_in(lo_clk), .pin_clock_input(pin_clk));

    task automatic close_out();
        $display("Compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus <= '0;
        @(posedge mclk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus <= '0;
        @(posedge mclk);
        d = rdata;
    endtask : rd

    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(n, e, d);
    endtask : rc

    task automatic wait_on(input int sel, input logic lvl);
        logic s;
        for (int n = 0; n < 400; n++) begin
            @(posedge mclk);
            s = sel == 0 ? t_irq : sel == 1 ? c_irq : tog;
            if (s === lvl) return;
        end
        fails++;
        $display("ERROR wait %0d expected %b seen timeout", sel, lvl);
        close_out();
    endtask : wait_on

    function automatic logic [31:0] ctl(input logic [1:0] m, input logic ie, input logic ev,
                                        input logic [1:0] s);
        return (32'h0000_0001 << CTL_EN_BIT) | (32'(ie) << CTL_IEN_BIT)
             | (32'(m) << CTL_MODE_LSB) | (32'(ev) << CTL_EVT_BIT) | (32'(s) << CTL_SRC_LSB);
    endfunction : ctl

    // Stop and clear the counter and flags, then start a mode
    task automatic go(input logic [1:0] m, input logic ie, input logic ev, input logic [1:0] s,
                      input logic [31:0] c0, input logic [31:0] ext);
        wr(OFS_CTRL, 32'h0400_0000);
        wr(OFS_CMP_STS, 32'h0000_0003);
        wr(OFS_CAP_STS, 32'h0000_0003);
        wr(OFS_EXT_CTRL, ext);
        wr(OFS_CMP0, c0);
        wr(OFS_CTRL, ctl(m, ie, ev, s));
    endtask : go

    task automatic t_reset();
        rc("ctrl reset", OFS_CTRL, CTL_RESET);
        rc("unmapped", 8'h24, 32'h0000_0000);
        chk("toggle idle", 1, tog);
    endtask : t_reset

    task automatic t_oneshot();
        go(MODE_ONESHOT, 1'b1, 1'b0, SRC_BUS, 32'h0000_0003, 32'h0000_0000);
        wait_on(0, 1'b1);
        rc("oneshot ctrl", OFS_CTRL, 32'h2000_0000);
        rc("oneshot count", OFS_COUNT, 32'h0000_0000);
        rc("oneshot status", OFS_CMP_STS, 32'h0000_0003);
    endtask : t_oneshot

    task automatic t_periodic();
        go(MODE_PERIODIC, 1'b0, 1'b0, SRC_BUS, 32'h0000_0007, 32'h0000_0000);
        repeat (20) @(posedge mclk);
        rc("periodic status", OFS_CMP_STS, 32'h0000_0002);
        chk("timer irq off", 0, t_irq);
        wr(OFS_CMP_STS, 32'h0000_0002);
        repeat (20) @(posedge mclk);
        rd(OFS_COUNT, v);
        chk("count wraps", 1, v <= 7);
        rc("periodic again", OFS_CMP_STS, 32'h0000_0002);
    endtask : t_periodic

    task automatic t_toggle();
        int n;
        go(MODE_TOGGLE, 1'b1, 1'b0, SRC_BUS, 32'h0000_0009, 32'h0000_0000);
        wait_on(2, 1'b0);
        wr(OFS_CMP_STS, 32'h0000_0003);
        wait_on(2, 1'b1);
        // High phase lasts one compare period of ten steps
        for (n = 0; n < 40 && tog === 1'b1; n++) begin
            @(posedge mclk);
        end
        chk("toggle half period", 32'h0000_000A, n);
    endtask : t_toggle

    task automatic t_cont();
        wr(OFS_CMP1, 32'h0000_001E);
        wr(OFS_CMP2, 32'hFFFF_FFFF);
        go(MODE_CONT, 1'b1, 1'b0, SRC_BUS, 32'hFFFF_FFFF, 32'h0000_0000);
        wait_on(0, 1'b1);
        rd(OFS_COUNT, v);
        chk("count past slot", 1, v > 30 && v < 40);
        wr(OFS_CMP_STS, 32'h0000_0003);
        wr(OFS_CMP2, v + 40);
        wait_on(0, 1'b1);
        rd(OFS_COUNT, w);
        chk("new slot", 1, w > v + 40 && w < v + 50);
    endtask : t_cont

    task automatic t_source();
        for (int i = 1; i <= 2; i++) begin
            go(MODE_CONT, 1'b0, 1'b0, 2'(i), 32'hFFFF_FFFF, 32'h0000_0000);
            repeat (200) @(posedge mclk);
            rd(OFS_COUNT, v);
            w = 200 / (30 - 10 * i);
            chk("source count", 1, v + 2 >= w && v <= w + 2);
        end
        // Bus clock through a prescale of 3: one step per four cycles
        wr(OFS_CTRL, 32'h0400_0000);
        wr(OFS_CTRL, ctl(MODE_CONT, 1'b0, 1'b0, SRC_BUS) | 32'h0000_0003);
        repeat (200) @(posedge mclk);
        rd(OFS_COUNT, v);
        chk("prescaled count", 1, v >= 49 && v <= 52);
    endtask : t_source

    task automatic t_event();
        // Rising edges with debounce, then falling edges without it
        for (int k = 0; k < 2; k++) begin
            go(MODE_PERIODIC, 1'b0, 1'b1, SRC_BUS, 32'h0000_0002,
               (k == 0) ? 32'h0000_0081 : 32'h0000_0000);
            repeat (4) begin
                ev_req <= 1'b1;
                repeat (12) @(posedge mclk);
                ev_req <= 1'b0;
                repeat (12) @(posedge mclk);
            end
            rc("event count", OFS_COUNT, 32'h0000_0001);
            rc("event status", OFS_CMP_STS, 32'h0000_0002);
        end
    endtask : t_event

    task automatic t_capture();
        go(MODE_CONT, 1'b0, 1'b0, SRC_BUS, 32'hFFFF_FFFF, 32'h0000_002C);
        cap_req <= 1'b1;
        wait_on(1, 1'b1);
        rd(OFS_CAPTURE, v);
        chk("capture taken", 1, v != 0);
        cap_req <= 1'b0;
        repeat (20) @(posedge mclk);
        rc("capture held", OFS_CAPTURE, v);
        wr(OFS_CAP_STS, 32'h0000_0000);
        rc("cap status", OFS_CAP_STS, 32'h0000_0003);
        wr(OFS_CAP_STS, 32'h0000_0003);
        chk("capture irq", 0, c_irq);
    endtask : t_capture

    task automatic t_extreset();
        go(MODE_CONT, 1'b0, 1'b0, SRC_BUS, 32'hFFFF_FFFF, 32'h0000_0058);
        cap_req <= 1'b1;
        repeat (40) @(posedge mclk);
        cap_req <= 1'b0;
        repeat (10) @(posedge mclk);
        rd(OFS_COUNT, v);
        chk("count cleared", 1, v < 14);
    endtask : t_extreset

    task automatic t_trigger();
        go(MODE_CONT, 1'b0, 1'b0, SRC_BUS, 32'hFFFF_FFFF, 32'h0000_012A);
        cap_req <= 1'b1;
        repeat (20) @(posedge mclk);
        cap_req <= 1'b0;
        repeat (20) @(posedge mclk);
        cap_req <= 1'b1;
        wait_on(1, 1'b1);
        rd(OFS_CAPTURE, v);
        chk("trigger span", 1, v >= 38 && v <= 42);
    endtask : t_trigger

    // Main sequence
    initial begin
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        repeat (4) @(posedge mclk);
        t_reset();
        t_oneshot();
        t_periodic();
        t_toggle();
        t_cont();
        t_source();
        t_event();
        t_capture();
        t_extreset();
        t_trigger();
        close_out();
    end
endmodule : testbench
`default_nettype wire
